// File: cpuseq_cfg.svh
`ifndef CPUSEQ_CFG_SVH
`define CPUSEQ_CFG_SVH

// program counter and return stack geometry
`define CPUSEQ_PC_W 13
`define CPUSEQ_PAGE_W 8
`define CPUSEQ_STACK_DEPTH 8
`define CPUSEQ_STACK_PTR_W 3
`define CPUSEQ_STACK_CNT_W 4
`define CPUSEQ_INSTR_W 16
`define CPUSEQ_DATA_W 8

// reset values
`define CPUSEQ_RESET_PC 13'h0000
`define CPUSEQ_RESET_PHASES 4'h1
`define CPUSEQ_RESET_STATUS 4'h0
`define CPUSEQ_RESET_RUN 1'b1

// register byte offsets
`define CPUSEQ_ADDR_W 8
`define CPUSEQ_OFF_PCL 8'h00
`define CPUSEQ_OFF_STATUS 8'h04
`define CPUSEQ_OFF_CTRL 8'h08

// status and control bit positions
`define CPUSEQ_ST_C 0
`define CPUSEQ_ST_AC 1
`define CPUSEQ_ST_Z 2
`define CPUSEQ_ST_OV 3
`define CPUSEQ_CTRL_RUN 0

// bus response codes
`define CPUSEQ_RESP_OKAY 2'h0
`define CPUSEQ_RESP_SLVERR 2'h2

`endif

// File: cpuseq_pkg.sv
`include "cpuseq_cfg.svh"

package cpuseq_pkg;

   // decoder's class of the executing instruction
   typedef enum logic [2:0] {
      cls_normal,
      cls_extended,
      jump_op,
      call_op,
      subroutine_return_op,
      interrupt_return_op,
      skip_if_zero_op,
      skip_if_nonzero_op
   } cpuseq_class_type;

   typedef enum logic [3:0] {
      alu_pass, alu_add, alu_adc, alu_sub, alu_sbc, alu_and, alu_or,
      alu_xor, alu_cpl, alu_rr, alu_rrc, alu_rl, alu_rlc, alu_inc, alu_dec
   } cpuseq_alu_op_type;

   // kind of the current instruction cycle
   typedef enum logic [1:0] {
      mode_run,
      mode_ext,
      mode_flush
   } cpuseq_mode_type;

   typedef enum logic [1:0] {
      reg_none,
      reg_pcl,
      reg_status,
      reg_ctrl
   } cpuseq_reg_type;

   typedef struct packed {
      logic [`CPUSEQ_STACK_DEPTH-1:0][`CPUSEQ_PC_W-1:0] slot;
      logic [`CPUSEQ_STACK_PTR_W-1:0] wp;
      logic [`CPUSEQ_STACK_CNT_W-1:0] count;
   } cpuseq_stack_state_type;

   typedef struct packed {
      logic [3:0] phases;
      cpuseq_mode_type mode;
      logic [`CPUSEQ_PC_W-1:0] pc;
      logic [`CPUSEQ_PC_W-1:0] pf_addr;
      logic [`CPUSEQ_PC_W-1:0] ir_addr;
      logic [`CPUSEQ_INSTR_W-1:0] pf_word;
      logic [`CPUSEQ_INSTR_W-1:0] ir;
      logic pf_valid;
      logic ir_valid;
      logic [3:0] status;
      logic run;
      logic pcl_pend;
      logic [`CPUSEQ_PAGE_W-1:0] pcl_val;
      logic [`CPUSEQ_DATA_W-1:0] result;
      logic [`CPUSEQ_DATA_W-1:0] result_dest;
      logic result_we;
      logic int_ack;
      logic int_return;
      logic aw_got;
      logic [`CPUSEQ_ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cpuseq_core_state_type;

endpackage

// File: cpuseq_if.sv
`include "cpuseq_cfg.svh"

// return stack port; push and pop are strobes
interface cpuseq_stack_if;
   logic push;
   logic pop;
   logic [`CPUSEQ_PC_W-1:0] push_pc;
   logic [`CPUSEQ_PC_W-1:0] top_pc;
   logic full;
   logic empty;
   modport core (output push, pop, push_pc, input top_pc, full, empty);
   modport store (input push, pop, push_pc, output top_pc, full, empty);
endinterface

// combinational alu port; flags are {ov, z, ac, c}
interface cpuseq_alu_if;
   cpuseq_pkg::cpuseq_alu_op_type op;
   logic [`CPUSEQ_DATA_W-1:0] a;
   logic [`CPUSEQ_DATA_W-1:0] b;
   logic cin;
   logic [`CPUSEQ_DATA_W-1:0] result;
   logic [3:0] flags;
   logic [3:0] upd;
   modport core (output op, a, b, cin, input result, flags, upd);
   modport unit (input op, a, b, cin, output result, flags, upd);
endinterface

// File: cpuseq_stack.sv
`include "cpuseq_cfg.svh"

module cpuseq_stack (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // port to the sequencer
   cpuseq_stack_if.store bus
);

   cpuseq_pkg::cpuseq_stack_state_type s;
   cpuseq_pkg::cpuseq_stack_state_type next_s;
   logic [`CPUSEQ_STACK_PTR_W-1:0] top_idx;

   // circular store: a push when full overwrites the oldest
   assign top_idx = s.wp - `CPUSEQ_STACK_PTR_W'(1);
   assign bus.top_pc = s.slot[top_idx];
   assign bus.full = (s.count == `CPUSEQ_STACK_CNT_W'(`CPUSEQ_STACK_DEPTH));
   assign bus.empty = (s.count == '0);

   // push, pop and level tracking
   always_comb begin
      next_s = s;
      if (bus.push) begin
         next_s.slot[s.wp] = bus.push_pc;
         next_s.wp = s.wp + `CPUSEQ_STACK_PTR_W'(1);
         if (!bus.full) begin
            next_s.count = s.count + `CPUSEQ_STACK_CNT_W'(1);
         end
      end else if (bus.pop && !bus.empty) begin
         next_s.wp = top_idx;
         next_s.count = s.count - `CPUSEQ_STACK_CNT_W'(1);
      end
   end

   // empty stack after reset; slot contents are cleared too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

// File: cpuseq_alu.sv
`include "cpuseq_cfg.svh"

module cpuseq_alu (
   // operands in, result and flags out
   cpuseq_alu_if.unit bus
);

   logic [`CPUSEQ_DATA_W-1:0] bx;
   logic cx;
   logic [`CPUSEQ_DATA_W:0] sum;
   logic [4:0] nib;

   // subtraction is add of the complement, so carry means no borrow
   always_comb begin
      bx = bus.b;
      cx = 1'b0;
      unique case (bus.op)
         cpuseq_pkg::alu_adc: cx = bus.cin;
         cpuseq_pkg::alu_sub: begin
            bx = ~bus.b;
            cx = 1'b1;
         end
         cpuseq_pkg::alu_sbc: begin
            bx = ~bus.b;
            cx = bus.cin;
         end
         cpuseq_pkg::alu_inc: begin
            bx = 8'h00;
            cx = 1'b1;
         end
         cpuseq_pkg::alu_dec: bx = 8'hFF;
         default: cx = 1'b0;
      endcase
   end

   assign sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, cx};
   assign nib = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};

   // result and the flags it may change
   always_comb begin
      bus.result = bus.a;
      bus.flags = 4'h0;
      bus.upd = 4'h4;
      unique case (bus.op)
         cpuseq_pkg::alu_add, cpuseq_pkg::alu_adc,
         cpuseq_pkg::alu_sub, cpuseq_pkg::alu_sbc: begin
            bus.result = sum[7:0];
            bus.flags[`CPUSEQ_ST_C] = sum[8];
            bus.flags[`CPUSEQ_ST_AC] = nib[4];
            bus.flags[`CPUSEQ_ST_OV] = (bus.a[7] == bx[7]) &&
                                       (sum[7] != bus.a[7]);
            bus.upd = 4'hF;
         end
         cpuseq_pkg::alu_inc, cpuseq_pkg::alu_dec: bus.result = sum[7:0];
         cpuseq_pkg::alu_and: bus.result = bus.a & bus.b;
         cpuseq_pkg::alu_or: bus.result = bus.a | bus.b;
         cpuseq_pkg::alu_xor: bus.result = bus.a ^ bus.b;
         cpuseq_pkg::alu_cpl: bus.result = ~bus.a;
         cpuseq_pkg::alu_rr: begin
            bus.result = {bus.a[0], bus.a[7:1]};
            bus.upd = 4'h0;
         end
         cpuseq_pkg::alu_rl: begin
            bus.result = {bus.a[6:0], bus.a[7]};
            bus.upd = 4'h0;
         end
         cpuseq_pkg::alu_rrc: begin
            bus.result = {bus.cin, bus.a[7:1]};
            bus.flags[`CPUSEQ_ST_C] = bus.a[0];
            bus.upd = 4'h1;
         end
         cpuseq_pkg::alu_rlc: begin
            bus.result = {bus.a[6:0], bus.cin};
            bus.flags[`CPUSEQ_ST_C] = bus.a[7];
            bus.upd = 4'h1;
         end
         default: bus.result = bus.a;
      endcase
      bus.flags[`CPUSEQ_ST_Z] = (bus.result == 8'h00);
   end

endmodule

// File: cpuseq_core.sv
`include "cpuseq_cfg.svh"

// Behaviour
// - four phases form one instruction cycle
// - first phase advances counter and fetches
// - fetch of next overlaps current execution
// - extended two cycles, branches one more
// - branch: branch cycle, then dummy cycle fetching target
// - 13-bit counter, low byte software visible
// - low byte write jumps in page, dummy
// - branches and reset load counter directly
// - taken skip discards prefetch, dummy cycle
// - eight level stack, hidden from software
// - call/interrupt push, returns pop counter
// - stack empty after reset
// - full stack withholds interrupt acknowledge
// - call on full stack loses oldest
// - 8-bit alu result to named register
// - alu updates status flags
// - execution starts fetching at zero
module cpuseq_core (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // axi4-lite register slave
   input logic [`CPUSEQ_ADDR_W-1:0] s_axi_awaddr,
   input logic [2:0] s_axi_awprot,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [`CPUSEQ_ADDR_W-1:0] s_axi_araddr,
   input logic [2:0] s_axi_arprot,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // program memory fetch port
   output logic [`CPUSEQ_PC_W-1:0] pmem_addr,
   output logic pmem_rd,
   input logic [`CPUSEQ_INSTR_W-1:0] pmem_data,
   // instruction in execution and its decode
   output logic [`CPUSEQ_INSTR_W-1:0] instr_word,
   output logic [`CPUSEQ_PC_W-1:0] instr_addr,
   output logic instr_valid,
   output logic exec_strobe,
   input cpuseq_pkg::cpuseq_class_type dec_class,
   input logic [`CPUSEQ_PC_W-1:0] dec_target,
   // alu request and result
   input logic alu_en,
   input cpuseq_pkg::cpuseq_alu_op_type alu_op,
   input logic [`CPUSEQ_DATA_W-1:0] alu_a,
   input logic [`CPUSEQ_DATA_W-1:0] alu_b,
   input logic [`CPUSEQ_DATA_W-1:0] alu_dest,
   output logic [`CPUSEQ_DATA_W-1:0] result_data,
   output logic [`CPUSEQ_DATA_W-1:0] result_dest,
   output logic result_we,
   output logic [3:0] status_flags,
   // interrupt controller
   input logic int_request,
   input logic [`CPUSEQ_PC_W-1:0] int_vector,
   output logic int_ack,
   output logic int_return,
   // sequencing state
   output logic [3:0] instruction_cycle_phases,
   output logic [4:0] pc_upper_bits
);

   cpuseq_pkg::cpuseq_core_state_type s;
   cpuseq_pkg::cpuseq_core_state_type next_s;
   cpuseq_pkg::cpuseq_reg_type wr_reg;
   cpuseq_pkg::cpuseq_reg_type rd_reg;
   logic t1;
   logic t2;
   logic t4;
   logic fetching;
   logic redirect;
   logic take_skip;
   logic wr_fire;

   cpuseq_stack_if stk ();
   cpuseq_alu_if alu ();

   // register map decode for both bus paths
   function automatic cpuseq_pkg::cpuseq_reg_type cpuseq_decode(
      input logic [`CPUSEQ_ADDR_W-1:0] addr);
      cpuseq_pkg::cpuseq_reg_type r;
      unique case (addr)
         `CPUSEQ_OFF_PCL: r = cpuseq_pkg::reg_pcl;
         `CPUSEQ_OFF_STATUS: r = cpuseq_pkg::reg_status;
         `CPUSEQ_OFF_CTRL: r = cpuseq_pkg::reg_ctrl;
         default: r = cpuseq_pkg::reg_none;
      endcase
      return r;
   endfunction

   cpuseq_stack u_stack (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(stk)
   );

   cpuseq_alu u_alu (
      .bus(alu)
   );

   // phase strobes; the ring only turns while running
   assign t1 = s.run && s.phases[0];
   assign t2 = s.run && s.phases[1];
   assign t4 = s.run && s.phases[3];
   assign fetching = s.mode != cpuseq_pkg::mode_ext;

   // alu operands from the decoder, carry from status
   assign alu.op = alu_op;
   assign alu.a = alu_a;
   assign alu.b = alu_b;
   assign alu.cin = s.status[`CPUSEQ_ST_C];

   // skip decided by this cycle's alu zero
   always_comb begin
      take_skip = 1'b0;
      if (dec_class == cpuseq_pkg::skip_if_zero_op) begin
         take_skip = alu.flags[`CPUSEQ_ST_Z];
      end else if (dec_class == cpuseq_pkg::skip_if_nonzero_op) begin
         take_skip = !alu.flags[`CPUSEQ_ST_Z];
      end
   end

   // handshake outputs from registered state
   assign pmem_rd = t1 && fetching;
   assign exec_strobe = t4 && s.ir_valid &&
                        (s.mode != cpuseq_pkg::mode_ext);
   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready = !s.w_got && !s.bvalid;
   assign s_axi_arready = !s.rvalid;
   assign wr_fire = s.aw_got && s.w_got;
   assign wr_reg = cpuseq_decode(s.awaddr);
   assign rd_reg = cpuseq_decode(s_axi_araddr);

   // data outputs from the state register
   assign pmem_addr = s.pc;
   assign instr_word = s.ir;
   assign instr_addr = s.ir_addr;
   assign instr_valid = s.ir_valid;
   assign result_data = s.result;
   assign result_dest = s.result_dest;
   assign result_we = s.result_we;
   assign status_flags = s.status;
   assign int_ack = s.int_ack;
   assign int_return = s.int_return;
   assign instruction_cycle_phases = s.phases;
   assign pc_upper_bits = s.pc[12:8];
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;

   // sequencer, writeback and register slave
   always_comb begin
      next_s = s;
      next_s.result_we = 1'b0;
      next_s.int_ack = 1'b0;
      next_s.int_return = 1'b0;
      redirect = 1'b0;
      stk.push = 1'b0;
      stk.pop = 1'b0;
      stk.push_pc = s.pf_addr;

      // four phase ring, T1 first
      if (s.run) begin
         next_s.phases = {s.phases[2:0], s.phases[3]};
      end

      // T1: fetch at pc, prefetched word enters execution
      if (t1 && fetching) begin
         next_s.pc = s.pc + `CPUSEQ_PC_W'(1);
         next_s.pf_addr = s.pc;
         next_s.pf_valid = 1'b1;
         next_s.ir = s.pf_word;
         next_s.ir_addr = s.pf_addr;
         // flush cycles execute nothing
         next_s.ir_valid = s.pf_valid &&
                           (s.mode == cpuseq_pkg::mode_run);
      end

      // T2: memory answers one cycle after the strobe
      if (t2 && fetching) begin
         next_s.pf_word = pmem_data;
      end

      // T4: retire and pick the next cycle
      if (t4) begin
         next_s.mode = cpuseq_pkg::mode_run;
         if (s.mode == cpuseq_pkg::mode_ext) begin
            next_s.mode = cpuseq_pkg::mode_run;
         end else if (s.ir_valid) begin
            if (alu_en) begin
               next_s.result = alu.result;
               next_s.result_dest = alu_dest;
               next_s.result_we = 1'b1;
               for (int i = 0; i < 4; i++) begin
                  if (alu.upd[i]) begin
                     next_s.status[i] = alu.flags[i];
                  end
               end
            end
            unique case (dec_class)
               cpuseq_pkg::cls_extended: begin
                  next_s.mode = cpuseq_pkg::mode_ext;
               end
               cpuseq_pkg::jump_op: begin
                  next_s.pc = dec_target;
                  redirect = 1'b1;
               end
               cpuseq_pkg::call_op: begin
                  // a full stack still takes the call
                  stk.push = 1'b1;
                  next_s.pc = dec_target;
                  redirect = 1'b1;
               end
               cpuseq_pkg::subroutine_return_op,
               cpuseq_pkg::interrupt_return_op: begin
                  stk.pop = 1'b1;
                  next_s.pc = stk.top_pc;
                  next_s.int_return =
                     dec_class == cpuseq_pkg::interrupt_return_op;
                  redirect = 1'b1;
               end
               cpuseq_pkg::skip_if_zero_op,
               cpuseq_pkg::skip_if_nonzero_op: begin
                  // pc already points past the skipped word
                  redirect = take_skip;
               end
               cpuseq_pkg::cls_normal: begin
                  redirect = 1'b0;
               end
            endcase
         end

         // software jump and interrupt only at a plain boundary
         if (!redirect && s.mode == cpuseq_pkg::mode_run &&
             next_s.mode == cpuseq_pkg::mode_run) begin
            if (s.pcl_pend) begin
               next_s.pc = {s.pc[12:8], s.pcl_val};
               next_s.pcl_pend = 1'b0;
               redirect = 1'b1;
            end else if (int_request && s.pf_valid && !stk.full) begin
               // push the address of the prefetched, unexecuted word
               stk.push = 1'b1;
               next_s.pc = int_vector;
               next_s.int_ack = 1'b1;
               redirect = 1'b1;
            end
         end
         if (redirect) begin
            next_s.mode = cpuseq_pkg::mode_flush;
         end
      end

      // write halves taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end

      // write once both halves are held
      if (wr_fire) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `CPUSEQ_RESP_OKAY;
         unique case (wr_reg)
            cpuseq_pkg::reg_pcl: begin
               if (s.wstrb[0]) begin
                  next_s.pcl_pend = 1'b1;
                  next_s.pcl_val = s.wdata[7:0];
               end
            end
            cpuseq_pkg::reg_status: begin
               // an alu update in the same cycle wins
               if (s.wstrb[0] && !(t4 && s.ir_valid && alu_en)) begin
                  next_s.status = s.wdata[3:0];
               end
            end
            cpuseq_pkg::reg_ctrl: begin
               if (s.wstrb[0]) begin
                  next_s.run = s.wdata[`CPUSEQ_CTRL_RUN];
               end
            end
            cpuseq_pkg::reg_none: begin
               next_s.bresp = `CPUSEQ_RESP_SLVERR;
            end
         endcase
      end else if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // read answer registered at the address edge
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `CPUSEQ_RESP_OKAY;
         next_s.rdata = 32'h00000000;
         unique case (rd_reg)
            cpuseq_pkg::reg_pcl: begin
               // low byte of the executing instruction's address
               next_s.rdata[7:0] = s.ir_addr[7:0];
            end
            cpuseq_pkg::reg_status: begin
               next_s.rdata[3:0] = s.status;
            end
            cpuseq_pkg::reg_ctrl: begin
               next_s.rdata[`CPUSEQ_CTRL_RUN] = s.run;
            end
            cpuseq_pkg::reg_none: begin
               next_s.rresp = `CPUSEQ_RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   // state register; no software path to the stack
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.phases <= `CPUSEQ_RESET_PHASES;
         s.mode <= cpuseq_pkg::mode_run;
         s.pc <= `CPUSEQ_RESET_PC;
         s.status <= `CPUSEQ_RESET_STATUS;
         s.run <= `CPUSEQ_RESET_RUN;
      end else begin
         s <= next_s;
      end
   end

endmodule

// File: cpuseq_checker.sv
module cpuseq_checker (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // fetch and execution
   input logic [12:0] pmem_addr,
   input logic pmem_rd,
   input logic [12:0] instr_addr,
   input logic instr_valid,
   input logic exec_strobe,
   input cpuseq_pkg::cpuseq_class_type dec_class,
   input logic [12:0] dec_target,
   // alu and interrupt
   input logic alu_en,
   input cpuseq_pkg::cpuseq_alu_op_type alu_op,
   input logic [7:0] alu_a,
   input logic [7:0] alu_dest,
   input logic result_we,
   input logic [7:0] result_dest,
   input logic int_ack,
   input logic [12:0] int_vector,
   input logic [3:0] instruction_cycle_phases
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_ring;
      $past(aresetn) |-> instruction_cycle_phases ==
         {$past(instruction_cycle_phases[2:0]),
          $past(instruction_cycle_phases[3])};
   endproperty
   a_ring: assert property (p_ring) else $error("phase ring broken");
   property p_fetch;
      pmem_rd |-> instruction_cycle_phases == 4'h1;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch off phase");
   property p_start;
      !$past(aresetn) |-> pmem_rd && pmem_addr == 13'h0000;
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_jdummy;
      exec_strobe && dec_class == cpuseq_pkg::jump_op |=>
         pmem_rd && pmem_addr == $past(dec_target) ##1 !instr_valid;
   endproperty
   a_jdummy: assert property (p_jdummy) else $error("no dummy");
   property p_jtarget;
      exec_strobe && dec_class == cpuseq_pkg::jump_op |=>
         ##5 instr_valid && instr_addr == $past(dec_target, 6);
   endproperty
   a_jtarget: assert property (p_jtarget) else $error("jump late");
   // taken skip refetches two past itself
   property p_skip;
      exec_strobe && dec_class == cpuseq_pkg::skip_if_zero_op && alu_en &&
         alu_op == cpuseq_pkg::alu_pass && alu_a == 8'h00 |=>
         pmem_addr == $past(instr_addr) + 13'h0002 ##1 !instr_valid;
   endproperty
   a_skip: assert property (p_skip) else $error("skip wrong");
   property p_ext;
      exec_strobe && dec_class == cpuseq_pkg::cls_extended |=>
         (!exec_strobe && !pmem_rd) [*4];
   endproperty
   a_ext: assert property (p_ext) else $error("extended short");
   property p_result;
      exec_strobe && alu_en |=> result_we && result_dest == $past(alu_dest);
   endproperty
   a_result: assert property (p_result) else $error("bad result");
   property p_ack;
      int_ack |-> ##[0:4] (pmem_rd && pmem_addr == int_vector);
   endproperty
   a_ack: assert property (p_ack) else $error("no vector fetch");
endmodule

bind cpuseq_core cpuseq_checker chk_i (.*);

// File: cpuseq_pmem_model.sv
module cpuseq_pmem_model (
   // fetch port seen from the memory
   input logic aclk,
   input logic [12:0] pmem_addr,
   input logic pmem_rd,
   output logic [15:0] pmem_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:8191];
   // default word: normal class, low field echoes its address
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = {3'h0, 13'(i)};
      pmem_data = 16'h0000;
   end
   // word one cycle after the strobe, scrambled otherwise
   always @(posedge aclk) begin
      if (pmem_rd) pmem_data <= mem[pmem_addr];
      else pmem_data <= ~pmem_data;
   end
endmodule

// File: tb_cpu_fetch_pc_stack_control.sv
module tb_cpu_fetch_pc_stack_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, pmem_rd, instr_valid;
   logic exec_strobe, alu_en, result_we, int_request, int_ack, int_return;
   logic [7:0] s_axi_awaddr, s_axi_araddr, alu_a, alu_b, alu_dest;
   logic [7:0] result_data, result_dest, res_d, res_t;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_wstrb, status_flags, instruction_cycle_phases;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [12:0] pmem_addr, instr_addr, dec_target, int_vector;
   logic [15:0] pmem_data, instr_word;
   logic [4:0] pc_upper_bits;
   cpuseq_pkg::cpuseq_class_type dec_class;
   cpuseq_pkg::cpuseq_alu_op_type alu_op;
   logic [12:0] log [$];
   logic [12:0] exp [$];
   int bad_count, total_checks, cycles, acks, rets, n;
   cpuseq_core uut (.*);
   cpuseq_pmem_model pm (.*);
   always #20 aclk = ~aclk;
   // decoder stand-in fed from the word
   always @(posedge aclk) begin
      dec_class <= cpuseq_pkg::cpuseq_class_type'(instr_word[15:13]);
      dec_target <= instr_word[12:0];
      alu_a <= instr_word[7:0];
   end
   // monitor and hang guard
   always @(posedge aclk) begin
      cycles++;
      if (exec_strobe === 1'b1) log.push_back(instr_addr);
      if (result_we === 1'b1) {res_d, res_t} = {result_data, result_dest};
      if (int_ack === 1'b1) acks++;
      if (int_return === 1'b1) rets++;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   function logic [15:0] w(cpuseq_pkg::cpuseq_class_type c, logic [12:0] t);
      return {c, t};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_seq(input int base);
      for (int i = 0; i < exp.size(); i++) chk("exec", exp[i], log[base+i]);
   endtask
   task wait_exec(input logic [12:0] a);
      n = 0;
      while (!(a inside {log}) && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      if (n == 2000) bad_count++;
   endtask
   // aw and w together; bready held until bvalid
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {rd, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, int_request, alu_en} = 4'h1;
      {s_axi_awaddr, s_axi_araddr, alu_b, alu_dest} = 32'h0;
      {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
      s_axi_wstrb = 4'hF;
      int_vector = 13'h030;
      alu_op = cpuseq_pkg::alu_pass;
      repeat (8) @(posedge aclk);
      pm.mem[13'h002] = w(cpuseq_pkg::jump_op, 13'h010);
      pm.mem[13'h010] = w(cpuseq_pkg::call_op, 13'h020);
      pm.mem[13'h020] = w(cpuseq_pkg::cls_extended, 13'h020);
      pm.mem[13'h021] = w(cpuseq_pkg::subroutine_return_op, 13'h000);
      pm.mem[13'h011] = w(cpuseq_pkg::skip_if_zero_op, 13'h000);
      pm.mem[13'h014] = w(cpuseq_pkg::jump_op, 13'h113);
      pm.mem[13'h114] = w(cpuseq_pkg::jump_op, 13'h113);
      pm.mem[13'h1A1] = w(cpuseq_pkg::jump_op, 13'h040);
      pm.mem[13'h065] = w(cpuseq_pkg::jump_op, 13'h064);
      pm.mem[13'h030] = w(cpuseq_pkg::interrupt_return_op, 13'h000);
      // call ladder: each call skips three words
      for (int i = 0; i < 9; i++) begin
         pm.mem[13'h040+4*i] = w(cpuseq_pkg::call_op, 13'(68+4*i));
         pm.mem[13'h042+4*i] = w(cpuseq_pkg::subroutine_return_op, 13'h0);
      end
      aresetn <= 1'b1;
      // jump, call, extended, return, taken skip
      wait_exec(13'h114);
      exp = '{13'h000, 13'h001, 13'h002, 13'h010, 13'h020, 13'h021, 13'h011,
             13'h013, 13'h014};
      chk_seq(0);
      $display("test sequence done");
      alu_op <= cpuseq_pkg::alu_add;
      alu_b <= 8'hF0;
      alu_dest <= 8'h2A;
      log.delete();
      wait_exec(13'h114);
      repeat (2) @(posedge aclk);
      chk("sum", 32'h03, res_d);
      chk("dest", 32'h2A, res_t);
      axi_rd(8'h04);
      chk("status", 32'h1, rd);
      $display("test alu done");
      axi_wr(8'h00, 32'h000000A0);
      chk("pcl bresp", 32'h0, rr);
      wait_exec(13'h1A0);
      chk("page", 32'h01, pc_upper_bits);
      axi_rd(8'h0C);
      chk("unmapped rresp", 32'h2, rr);
      chk("unmapped rdata", 32'h0, rd);
      axi_wr(8'h0C, 32'h000000FF);
      chk("unmapped bresp", 32'h2, rr);
      $display("test pcl done");
      wait_exec(13'h065);
      int_request <= 1'b1;
      repeat (60) @(posedge aclk);
      chk("ack withheld", 32'h0, acks);
      pm.mem[13'h065] = w(cpuseq_pkg::subroutine_return_op, 13'h000);
      n = 0;
      while (acks == 0 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      int_request <= 1'b0;
      wait_exec(13'h046);
      exp = '{13'h065, 13'h061, 13'h030, 13'h062};
      for (int k = 0; k < 7; k++) begin
         exp.push_back(13'h05D - 13'(4*k));
         exp.push_back(13'h05E - 13'(4*k));
      end
      chk_seq(log.size() - exp.size());
      chk("acks", 32'h1, acks);
      chk("returns", 32'h1, rets);
      $display("test stack done");
      print_verdict();
   end
endmodule
